//--- common/vm_seq_pkg.sv
// constants, register map and state encoding for the virtual-mode interrupt sequencer
package vm_seq_pkg;
  // flag bit positions in the 32-bit flags register
  localparam int          TF_BIT      = 8;
  localparam int          IF_BIT      = 9;
  localparam int          NT_BIT      = 14;
  localparam int          VM_BIT      = 17;
  localparam int          HALF_W      = 16;
  // gate type codes
  localparam logic [3:0]  GATE_INT16  = 4'h6;
  localparam logic [3:0]  GATE_TRAP16 = 4'h7;
  localparam logic [3:0]  GATE_INT32  = 4'hE;
  localparam logic [3:0]  GATE_TRAP32 = 4'hF - 4'h1;
  localparam logic [3:0]  GATE_INT32B = 4'hF;
  // privilege levels
  localparam logic [1:0]  PL_KERNEL   = 2'h0;
  localparam logic [1:0]  PL_VIRT     = 2'h3;
  localparam logic [15:0] NULL_SEL    = 16'h0000;
  localparam logic [15:0] UNDEF_HI    = 16'h0000;
  // stack geometry
  localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
  localparam logic [31:0] FLAGS_OFS   = 32'h0000_0008;
  localparam logic [31:0] SEGS_OFS    = 32'h0000_0008;
  localparam logic [3:0]  LAST_PUSH   = 4'h8;
  localparam logic [3:0]  LAST_DSEG   = 4'h3;
  // segment register array index
  localparam logic [2:0]  SEG_ES      = 3'h0;
  localparam logic [2:0]  SEG_CS      = 3'h1;
  localparam logic [2:0]  SEG_SS      = 3'h2;
  localparam logic [2:0]  SEG_DS      = 3'h3;
  localparam logic [2:0]  SEG_FS      = 3'h4;
  localparam logic [2:0]  SEG_GS      = 3'h5;
  localparam int          NUM_SEG     = 6;
  // register word index, byte address is index times four
  localparam logic [3:0]  IDX_FLAGS   = 4'h0;
  localparam logic [3:0]  IDX_ESP     = 4'h1;
  localparam logic [3:0]  IDX_EIP     = 4'h2;
  localparam logic [3:0]  IDX_SEG0    = 4'h3;
  localparam logic [3:0]  IDX_SEG5    = 4'h8;
  localparam logic [3:0]  IDX_SS0     = 4'h9;
  localparam logic [3:0]  IDX_ESP0    = 4'hA;
  localparam logic [3:0]  IDX_STATUS  = 4'hB;
  localparam logic [31:0] AHB_MAP_TOP = 32'h0000_0030;
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_ENT_PUSH  = 4'b0001,
    ST_ENT_LOAD  = 4'b0010,
    ST_RET_FLAGS = 4'b0011,
    ST_RET_EIP   = 4'b0100,
    ST_RET_CS    = 4'b0101,
    ST_RET_SEGS  = 4'b0110,
    ST_RET_CHECK = 4'b0111,
    ST_RET_ESP   = 4'b1000,
    ST_RET_SS    = 4'b1001
  } seq_state_e;
endpackage

//--- design/ahb_reg_port.sv
// ahb-lite slave front end: one wait state, registered answer
`timescale 1ns/10ps
`default_nettype none
module ahb_reg_port
  import vm_seq_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] rd_data_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  output logic [3:0]       idx_o,
  output logic             wr_o,
  output logic [31:0]      wdata_o
);
  logic       pend_r;
  logic       wr_r;
  logic       map_r;
  logic [3:0] idx_r;
  logic       take;

  // htrans bit 1 marks nonseq or seq; only word transfers are served
  assign take    = hsel_i & htrans_i[1] & hready_i;
  assign idx_o   = idx_r;
  assign wr_o    = pend_r & wr_r & map_r;
  assign wdata_o = hwdata_i;
  assign hresp_o = 1'b0;

  // address phase capture, one wait state, then done
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_r      <= 1'b0;
      wr_r        <= 1'b0;
      map_r       <= 1'b0;
      idx_r       <= 4'h0;
      hreadyout_o <= 1'b1;
      hrdata_o    <= 32'h0000_0000;
    end else if (clk_en_i) begin
      if (pend_r) begin
        pend_r      <= 1'b0;
        hreadyout_o <= 1'b1;
        // unmapped reads answer zero
        hrdata_o    <= (!wr_r && map_r) ? rd_data_i : 32'h0000_0000;
      end else if (take) begin
        pend_r      <= 1'b1;
        wr_r        <= hwrite_i;
        map_r       <= (haddr_i < AHB_MAP_TOP) && (hsize_i == 3'h2);
        idx_r       <= haddr_i[5:2];
        hreadyout_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- design/vm_interrupt_sequencer.sv
// virtual-mode interrupt entry and interrupt-return sequencer
`timescale 1ns/10ps
`default_nettype none
module vm_interrupt_sequencer
  import vm_seq_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  // register bus
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // interrupt entry request
  input  wire logic        int_req_i,
  input  wire logic [3:0]  gate_type_i,
  input  wire logic        gate_conforming_i,
  input  wire logic [1:0]  gate_dpl_i,
  input  wire logic [15:0] gate_cs_i,
  input  wire logic [31:0] gate_eip_i,
  // interrupt return request
  input  wire logic        interrupt_return_req_i,
  input  wire logic        interrupt_return_op32_i,
  input  wire logic [3:0]  seg_valid_i,
  // stack memory
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic [31:0]      mem_addr_o,
  output logic [31:0]      mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  // events and state
  output logic             gp_fault_o,
  output logic [15:0]      fault_code_o,
  output logic             task_return_o,
  output logic             done_o,
  output logic             seg_load_o,
  output logic [2:0]       seg_load_idx_o,
  output logic             seg_load_real_o,
  output logic             virtual_mode_o,
  output logic [1:0]       cpl_o
);
  // the stack port carries plain 32-bit addresses
  if (ADDR_W != 32) begin : g_bad_width
    $error("ADDR_W must be 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_s1_r;
  logic rst_n;

  // two stages so release never lands mid-edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else if (clk_en_i) begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // architectural state
  seq_state_e  state_r;
  logic [31:0] flags_r;
  logic [31:0] esp_r;
  logic [31:0] eip_r;
  logic [15:0] seg_r [NUM_SEG];
  logic [15:0] ss0_r;
  logic [31:0] esp0_r;
  logic [1:0]  cpl_r;
  logic [31:0] tmp_flags_r;
  logic [15:0] old_ss_r;
  logic [31:0] old_esp_r;
  logic [15:0] gcs_r;
  logic [31:0] geip_r;
  logic [31:0] ss_addr_r;
  logic        op32_r;
  logic [3:0]  step_r;
  logic [31:0] acc_addr;
  logic        acc_we;
  logic [31:0] acc_data;
  logic        gate_ok;
  logic        gate16;
  logic        gate_int;
  logic [31:0] rd_data;
  logic [3:0]  reg_idx;
  logic        reg_wr;
  logic [31:0] reg_wdata;

  assign virtual_mode_o = flags_r[VM_BIT]; // 17
  assign cpl_o          = cpl_r;

  // data segment index for a push or load step
  function automatic logic [2:0] dseg_of(input logic [3:0] s, input logic push);
    logic [2:0] r;
    r = SEG_ES;
    case (s[1:0])
      2'h0:    r = push ? SEG_GS : SEG_ES;
      2'h1:    r = push ? SEG_FS : SEG_DS;
      2'h2:    r = push ? SEG_DS : SEG_FS;
      2'h3:    r = push ? SEG_ES : SEG_GS;
      default: r = SEG_ES;
    endcase
    return r;
  endfunction

  // gate checks: 16- and 32-bit gate types, non-conforming, ring 0
  always_comb begin
    gate16   = (gate_type_i == GATE_INT16) || (gate_type_i == GATE_TRAP16);
    gate_int = (gate_type_i == GATE_INT16) || (gate_type_i == GATE_INT32B);
    gate_ok  = (gate16 || (gate_type_i == GATE_TRAP32) || (gate_type_i == GATE_INT32B))
               && !gate_conforming_i && (gate_dpl_i == PL_KERNEL);
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack access for the current step
  always_comb begin
    acc_we   = 1'b0;
    acc_addr = esp_r;
    acc_data = 32'h0000_0000;
    case (state_r)
      ST_ENT_PUSH: begin
        acc_we   = 1'b1;
        acc_addr = esp_r - WORD_BYTES;
        case (step_r)
          4'h4:    acc_data = {UNDEF_HI, old_ss_r};
          4'h5:    acc_data = old_esp_r;
          4'h6:    acc_data = tmp_flags_r;
          4'h7:    acc_data = {UNDEF_HI, seg_r[SEG_CS]};
          4'h8:    acc_data = eip_r;
          default: acc_data = {UNDEF_HI, seg_r[dseg_of(step_r, 1'b1)]};
        endcase
      end
      ST_RET_FLAGS: acc_addr = esp_r + FLAGS_OFS;
      ST_RET_SEGS:  acc_addr = esp_r + SEGS_OFS + {26'h0, step_r, 2'h0};
      ST_RET_SS:    acc_addr = ss_addr_r;
      default:      acc_addr = esp_r;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer, architectural registers and stack port
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r         <= ST_IDLE;
      flags_r         <= 32'h0000_0000;
      esp_r           <= 32'h0000_0000;
      eip_r           <= 32'h0000_0000;
      for (int i = 0; i < NUM_SEG; i++) begin
        seg_r[i] <= NULL_SEL;
      end
      ss0_r           <= NULL_SEL;
      esp0_r          <= 32'h0000_0000;
      cpl_r           <= PL_KERNEL;
      tmp_flags_r     <= 32'h0000_0000;
      old_ss_r        <= NULL_SEL;
      old_esp_r       <= 32'h0000_0000;
      gcs_r           <= NULL_SEL;
      geip_r          <= 32'h0000_0000;
      ss_addr_r       <= 32'h0000_0000;
      op32_r          <= 1'b0;
      step_r          <= 4'h0;
      mem_req_o       <= 1'b0;
      mem_we_o        <= 1'b0;
      mem_addr_o      <= 32'h0000_0000;
      mem_wdata_o     <= 32'h0000_0000;
      gp_fault_o      <= 1'b0;
      fault_code_o    <= NULL_SEL;
      task_return_o   <= 1'b0;
      done_o          <= 1'b0;
      seg_load_o      <= 1'b0;
      seg_load_idx_o  <= SEG_ES;
      seg_load_real_o <= 1'b0;
    end else if (clk_en_i) begin
      gp_fault_o    <= 1'b0;
      task_return_o <= 1'b0;
      done_o        <= 1'b0;
      seg_load_o    <= 1'b0;
      // issue the access of a stepping state once, hold until acked
      if (state_r != ST_IDLE && state_r != ST_ENT_LOAD && state_r != ST_RET_CHECK
          && !mem_req_o) begin
        mem_req_o   <= 1'b1;
        mem_we_o    <= acc_we;
        mem_addr_o  <= acc_addr;
        mem_wdata_o <= acc_data;
      end
      if (mem_req_o && mem_ack_i) begin
        mem_req_o <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          // entry wins over return when both arrive together in virtual mode; with VM clear the entry request is ignored
          if (int_req_i && flags_r[VM_BIT]) begin
            if (!gate_ok) begin
              gp_fault_o   <= 1'b1;
              fault_code_o <= gate_cs_i;
            end else begin
              // a 16-bit gate only keeps the low half, so VM is lost
              tmp_flags_r <= gate16 ? {UNDEF_HI, flags_r[HALF_W-1:0]} : flags_r;
              flags_r[VM_BIT] <= 1'b0;
              flags_r[TF_BIT] <= 1'b0;
              if (gate_int) begin
                flags_r[IF_BIT] <= 1'b0;
              end
              old_ss_r        <= seg_r[SEG_SS];
              old_esp_r       <= esp_r;
              seg_r[SEG_SS]   <= ss0_r;
              esp_r           <= esp0_r;
              cpl_r           <= PL_KERNEL;
              seg_load_o      <= 1'b1;
              seg_load_idx_o  <= SEG_SS;
              seg_load_real_o <= 1'b0;
              gcs_r           <= gate_cs_i;
              geip_r          <= gate_eip_i;
              step_r          <= 4'h0;
              state_r         <= ST_ENT_PUSH;
            end
          end else if (interrupt_return_req_i) begin
            if (flags_r[NT_BIT]) begin
              task_return_o <= 1'b1;
            end else begin
              op32_r  <= interrupt_return_op32_i;
              state_r <= ST_RET_FLAGS;
            end
          end else if (reg_wr) begin
            // software may only touch state while the sequencer rests
            case (reg_idx)
              IDX_FLAGS: flags_r <= reg_wdata;
              IDX_ESP:   esp_r   <= reg_wdata;
              IDX_EIP:   eip_r   <= reg_wdata;
              IDX_SS0:   ss0_r   <= reg_wdata[HALF_W-1:0];
              IDX_ESP0:  esp0_r  <= reg_wdata;
              IDX_STATUS: cpl_r  <= reg_wdata[1:0];
              default: begin
                if (reg_idx >= IDX_SEG0 && reg_idx <= IDX_SEG5) begin
                  seg_r[3'(reg_idx - IDX_SEG0)] <= reg_wdata[HALF_W-1:0];
                end
              end
            endcase
          end
        end
        ST_ENT_PUSH: begin
          if (mem_req_o && mem_ack_i) begin
            esp_r <= esp_r - WORD_BYTES;
            if (step_r == LAST_DSEG) begin
              seg_r[SEG_ES] <= NULL_SEL;
              seg_r[SEG_DS] <= NULL_SEL;
              seg_r[SEG_FS] <= NULL_SEL;
              seg_r[SEG_GS] <= NULL_SEL;
            end
            if (step_r == LAST_PUSH) begin
              state_r <= ST_ENT_LOAD;
            end else begin
              step_r <= step_r + 4'h1;
            end
          end
        end
        ST_ENT_LOAD: begin
          seg_r[SEG_CS]   <= gcs_r;
          eip_r           <= geip_r;
          seg_load_o      <= 1'b1;
          seg_load_idx_o  <= SEG_CS;
          seg_load_real_o <= 1'b0;
          done_o          <= 1'b1;
          state_r         <= ST_IDLE;
        end
        ST_RET_FLAGS: begin
          if (mem_req_o && mem_ack_i) begin
            if (!op32_r) begin
              flags_r[HALF_W-1:0] <= mem_rdata_i[HALF_W-1:0];
            end else begin
              flags_r <= mem_rdata_i;
              // outside ring 0 the mode bit stays as it was
              flags_r[VM_BIT] <= (cpl_r == PL_KERNEL) ? mem_rdata_i[VM_BIT]
                                                      : flags_r[VM_BIT];
            end
            state_r <= ST_RET_EIP;
          end
        end
        ST_RET_EIP: begin
          if (mem_req_o && mem_ack_i) begin
            eip_r   <= mem_rdata_i;
            esp_r   <= esp_r + WORD_BYTES;
            state_r <= ST_RET_CS;
          end
        end
        ST_RET_CS: begin
          if (mem_req_o && mem_ack_i) begin
            seg_r[SEG_CS]   <= mem_rdata_i[HALF_W-1:0];
            seg_load_o      <= 1'b1;
            seg_load_idx_o  <= SEG_CS;
            seg_load_real_o <= flags_r[VM_BIT];
            // pop the selector word and step over the flags image
            esp_r  <= esp_r + WORD_BYTES + WORD_BYTES;
            step_r <= 4'h0;
            if (flags_r[VM_BIT]) begin
              state_r <= ST_RET_SEGS;
            end else begin
              for (int k = 0; k < 4; k++) begin
                if (!seg_valid_i[k]) begin
                  seg_r[dseg_of(4'(k), 1'b0)] <= NULL_SEL;
                end
              end
              state_r <= ST_RET_CHECK;
            end
          end
        end
        ST_RET_SEGS: begin
          if (mem_req_o && mem_ack_i) begin
            seg_r[dseg_of(step_r, 1'b0)] <= mem_rdata_i[HALF_W-1:0];
            seg_load_o      <= 1'b1;
            seg_load_idx_o  <= dseg_of(step_r, 1'b0);
            seg_load_real_o <= 1'b1;
            if (step_r == LAST_DSEG) begin
              state_r <= ST_RET_CHECK;
            end else begin
              step_r <= step_r + 4'h1;
            end
          end
        end
        ST_RET_CHECK: begin
          // new level: 3 in virtual mode, else the selector's own
          cpl_r <= flags_r[VM_BIT] ? PL_VIRT : seg_r[SEG_CS][1:0];
          if (seg_r[SEG_CS][1:0] > cpl_r) begin
            state_r <= ST_RET_ESP;
          end else begin
            done_o  <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        ST_RET_ESP: begin
          if (mem_req_o && mem_ack_i) begin
            ss_addr_r <= esp_r + WORD_BYTES;
            esp_r     <= mem_rdata_i;
            state_r   <= ST_RET_SS;
          end
        end
        ST_RET_SS: begin
          if (mem_req_o && mem_ack_i) begin
            seg_r[SEG_SS]   <= mem_rdata_i[HALF_W-1:0];
            seg_load_o      <= 1'b1;
            seg_load_idx_o  <= SEG_SS;
            seg_load_real_o <= flags_r[VM_BIT];
            done_o          <= 1'b1;
            state_r         <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    case (reg_idx)
      IDX_FLAGS:  rd_data = flags_r;
      IDX_ESP:    rd_data = esp_r;
      IDX_EIP:    rd_data = eip_r;
      IDX_SS0:    rd_data = {UNDEF_HI, ss0_r};
      IDX_ESP0:   rd_data = esp0_r;
      IDX_STATUS: rd_data = {24'h0, state_r, 1'b0, (state_r != ST_IDLE), cpl_r};
      default: begin
        if (reg_idx >= IDX_SEG0 && reg_idx <= IDX_SEG5) begin
          rd_data = {UNDEF_HI, seg_r[3'(reg_idx - IDX_SEG0)]};
        end
      end
    endcase
  end

  ahb_reg_port u_bus (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .clk_en_i    (clk_en_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hwdata_i    (hwdata_i),
    .hready_i    (hready_i),
    .rd_data_i   (rd_data),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .hrdata_o    (hrdata_o),
    .idx_o       (reg_idx),
    .wr_o        (reg_wr),
    .wdata_o     (reg_wdata)
  );
endmodule
`default_nettype wire

//--- test/stack_mem_model.sv
// stack memory partner: word store with 0 to 3 wait cycles
`timescale 1ns/10ps
`default_nettype none
module stack_mem_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [1:0]  wait_i,
  output logic             ack_o,
  output logic [31:0]      rdata_o
);
  logic [31:0] mem [256];
  logic [1:0]  cnt;
  initial begin
    ack_o = 1'b0;
    cnt = 2'h0;
    rdata_o = 32'h0;
  end
  // read data toggles outside acks so stale values never look valid
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o) begin
      cnt <= (cnt == wait_i) ? 2'h0 : cnt + 2'h1;
      if (cnt == wait_i) begin
        ack_o <= 1'b1;
        if (we_i) mem[addr_i[9:2]] <= wdata_i;
        else rdata_o <= mem[addr_i[9:2]];
      end
    end
  end
endmodule
`default_nettype wire

//--- test/tb_top.sv
// bench: drives the sequencer, models the stack, checks pushes and registers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import vm_seq_pkg::*;
  logic        clk_i, reset_n_i, hwrite_i, int_req_i, interrupt_return_req_i, interrupt_return_op32_i, rd_ph;
  logic        gate_conforming_i, mem_req_o, mem_we_o, mem_ack_i, hreadyout_o;
  logic        gp_fault_o, task_return_o, done_o, virtual_mode_o;
  logic [1:0]  htrans_i, gate_dpl_i, cpl_o, wait_r;
  logic [3:0]  gate_type_i, seg_valid_i;
  logic [15:0] gate_cs_i, fault_code_o, s [NUM_SEG];
  logic [31:0] haddr_i, hwdata_i, hrdata_o, gate_eip_i, mem_addr_o, mem_wdata_o;
  logic [31:0] mem_rdata_i, seed, fl, stack_pointer_reg, ip;
  logic [63:0] exq [$];
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  vm_interrupt_sequencer dut (.clk_i, .reset_n_i, .clk_en_i(1'b1), .hsel_i(1'b1), .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o,
    .hresp_o(), .hrdata_o, .int_req_i, .gate_type_i, .gate_conforming_i, .gate_dpl_i,
    .gate_cs_i, .gate_eip_i, .interrupt_return_req_i, .interrupt_return_op32_i, .seg_valid_i, .mem_req_o, .mem_we_o,
    .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .gp_fault_o, .fault_code_o,
    .task_return_o, .done_o, .seg_load_o(), .seg_load_idx_o(), .seg_load_real_o(),
    .virtual_mode_o, .cpl_o);
  stack_mem_model mem (.clk_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .wait_i(wait_r), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one ahb single transfer, address held until hready seen high
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    @(posedge clk_i);
    while (!hreadyout_o) @(posedge clk_i);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    rd_ph <= !w;
    @(posedge clk_i);
    while (!hreadyout_o) @(posedge clk_i);
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exq.push_back({32'h0, e});
    bus(1'b0, a, 32'h0);
  endtask
  // request entry or return, then wait for its closing pulse
  task automatic go(input logic r, input logic [2:0] e);
    int n;
    n = 0;
    gate_cs_i <= 16'(rnd());
    gate_eip_i <= rnd();
    wait_r <= 2'(rnd());
    seg_valid_i <= 4'(rnd());
    int_req_i <= !r;
    interrupt_return_req_i <= r;
    @(posedge clk_i);
    int_req_i <= 1'b0;
    interrupt_return_req_i <= 1'b0;
    @(posedge clk_i);
    while (!(done_o | gp_fault_o | task_return_o) && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    chk("event", {61'h0, e}, {61'h0, gp_fault_o, task_return_o, done_o});
  endtask
  task automatic entry(input logic [3:0] t);
    logic [31:0] d [9];
    logic [31:0] fc;
    fl = (rnd() | 32'h0002_0300) & 32'hFFFF_BFFF;
    stack_pointer_reg = rnd();
    ip = rnd();
    bus(1'b1, 32'h00, fl);
    bus(1'b1, 32'h04, stack_pointer_reg);
    bus(1'b1, 32'h08, ip);
    for (int i = 0; i < NUM_SEG; i++) begin
      s[i] = 16'(rnd()) | {14'h0, i == 1, i == 1};
      bus(1'b1, 32'(12 + 4 * i), {16'h0, s[i]});
    end
    bus(1'b1, 32'h24, 32'h0000_0011);
    bus(1'b1, 32'h28, 32'h0000_0300);
    bus(1'b1, 32'h2C, 32'h0000_0003);
    d = '{{16'h0, s[5]}, {16'h0, s[4]}, {16'h0, s[3]}, {16'h0, s[0]}, {16'h0, s[2]}, stack_pointer_reg, fl,
          {16'h0, s[1]}, ip};
    for (int k = 0; k < 9; k++) exq.push_back({32'(768 - 4 * (k + 1)), d[k]});
    gate_type_i <= t;
    gate_conforming_i <= 1'b0;
    gate_dpl_i <= 2'h0;
    go(1'b0, 3'b001);
    chk("cpl", 64'h0, {62'h0, cpl_o});
    fc = fl;
    fc[VM_BIT] = 1'b0;
    fc[TF_BIT] = 1'b0;
    fc[IF_BIT] = (t == GATE_INT32B) ? 1'b0 : fl[IF_BIT];
    rd(32'h00, fc);
    rd(32'h08, gate_eip_i);
    rd(32'h10, {16'h0, gate_cs_i});
    rd(32'h0C, 32'h0);
    rd(32'h14, 32'h11);
  endtask
  // watcher: each push or read result is matched to the oldest note
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
    if ((mem_req_o && mem_we_o && mem_ack_i) || (rd_ph && hreadyout_o))
      chk("result", exq.size() ? exq.pop_front() : 64'hX,
          rd_ph ? {32'h0, hrdata_o} : {mem_addr_o, mem_wdata_o});
  end
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    {hwrite_i, int_req_i, interrupt_return_req_i, interrupt_return_op32_i, rd_ph, gate_conforming_i} = '0;
    {htrans_i, gate_dpl_i, wait_r, gate_type_i, seg_valid_i, gate_cs_i} = '0;
    {haddr_i, hwdata_i, gate_eip_i} = '0;
    reset_n_i = 1'b0;
    seed = 32'd74709;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(32'h40, 32'h0);
    for (int g = 0; g < 2; g++) begin
      entry(g ? GATE_INT32B : GATE_TRAP32);
      interrupt_return_op32_i <= 1'b1;
      go(1'b1, 3'b001);
      chk("vm", 64'h1, {63'h0, virtual_mode_o});
      rd(32'h00, fl);
      rd(32'h04, stack_pointer_reg);
      rd(32'h18, {16'h0, s[3]});
      rd(32'h10, {16'h0, s[1]});
    end
    for (int b = 0; b < 4; b++) begin
      gate_conforming_i <= (b == 0);
      gate_dpl_i <= 2'(b);
      go(1'b0, 3'b100);
      chk("code", {48'h0, gate_cs_i}, {48'h0, fault_code_o});
    end
    bus(1'b1, 32'h00, 32'h0000_4000);
    bus(1'b1, 32'h2C, 32'h0);
    go(1'b1, 3'b010);
    entry(GATE_INT32B);
    bus(1'b1, 32'h0C, 32'h0000_005A);
    interrupt_return_op32_i <= 1'b0;
    go(1'b1, 3'b001);
    chk("vm16", 64'h0, {63'h0, virtual_mode_o});
    rd(32'h00, {fl[31:16] & 16'hFFFD, fl[15:0]});
    rd(32'h0C, seg_valid_i[0] ? 32'h0000_005A : 32'h0);
    conclude();
  end
endmodule
`default_nettype wire

//--- test/vm_seq_asserts.sv
// assertion checker for the virtual-mode interrupt sequencer ports
`timescale 1ns/10ps
`default_nettype none
module vm_seq_asserts
  import vm_seq_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        int_req_i,
  input wire logic        interrupt_return_req_i,
  input wire logic        interrupt_return_op32_i,
  input wire logic        gate_conforming_i,
  input wire logic [1:0]  gate_dpl_i,
  input wire logic [15:0] gate_cs_i,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic        mem_ack_i,
  input wire logic [31:0] mem_addr_o,
  input wire logic        gp_fault_o,
  input wire logic [15:0] fault_code_o,
  input wire logic        task_return_o,
  input wire logic        done_o,
  input wire logic        seg_load_o,
  input wire logic [2:0]  seg_load_idx_o,
  input wire logic        seg_load_real_o,
  input wire logic        virtual_mode_o,
  input wire logic [1:0]  cpl_o
);
  logic        ent_r;
  logic        prev_r;
  logic [3:0]  cnt_r;
  logic [31:0] last_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////
  // entry bookkeeping: pushes seen and last pushed address
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i || done_o) begin
      ent_r  <= 1'b0;
      prev_r <= 1'b0;
      cnt_r  <= 4'h0;
      last_r <= 32'h0;
    end else if (mem_req_o && mem_we_o) begin
      ent_r <= 1'b1;
      if (mem_ack_i) begin
        prev_r <= 1'b1;
        cnt_r  <= cnt_r + 4'h1;
        last_r <= mem_addr_o;
      end
    end
  end
  a_gp_code: assert property (int_req_i && virtual_mode_o && gate_conforming_i
    |=> gp_fault_o && fault_code_o == $past(gate_cs_i)) else $error("fault code wrong");
  a_bad_nopush: assert property (int_req_i && virtual_mode_o && gate_dpl_i != 2'h0
    |=> !mem_req_o [*4]) else $error("push through bad gate");
  a_ent_mode: assert property (mem_req_o && mem_we_o
    |-> !virtual_mode_o && cpl_o == PL_KERNEL) else $error("push outside level 0");
  a_push_order: assert property (mem_req_o && mem_we_o && prev_r
    |-> mem_addr_o == last_r - WORD_BYTES) else $error("push address not descending");
  a_push_count: assert property (done_o && ent_r
    |-> cnt_r == 4'h9) else $error("push count wrong");
  a_cs_load: assert property (done_o && ent_r
    |-> seg_load_o && seg_load_idx_o == SEG_CS && !seg_load_real_o) else $error("no cs load");
  a_seg_sem: assert property (seg_load_o
    |-> seg_load_real_o == virtual_mode_o) else $error("segment load semantics wrong");
  a_task_ret: assert property (task_return_o
    |-> !mem_req_o [*4]) else $error("stack access on task return");
  a_ret16_vm: assert property (interrupt_return_req_i && !interrupt_return_op32_i && !virtual_mode_o && !mem_req_o
    && !int_req_i |=> !virtual_mode_o [*8]) else $error("short return set vm");
endmodule
bind vm_interrupt_sequencer vm_seq_asserts chk (.clk_i, .reset_n_i, .int_req_i, .interrupt_return_req_i,
  .interrupt_return_op32_i, .gate_conforming_i, .gate_dpl_i, .gate_cs_i, .mem_req_o, .mem_we_o, .mem_ack_i,
  .mem_addr_o, .gp_fault_o, .fault_code_o, .task_return_o, .done_o, .seg_load_o,
  .seg_load_idx_o, .seg_load_real_o, .virtual_mode_o, .cpl_o);
`default_nettype wire
